// ===== hdl/sdbg_dev.sv
// How it works
// - one open-drain pin carries both directions
// - host starts each bit with falling edge
// - device samples pin nine bus cycles later
// - msb first, sixteen bus cycles per bit
// - bus clock is system clock halved
// - hardware commands run while user code runs
// - commands reach any memory and registers
// - access uses an idle bus cycle
// - steal a cycle after bounded wait
// - 0x90 enters background only if enabled
// - 0xe4 byte read in map, lane by parity
// - status byte shows enable and active bits
// - 0xec aligned word read in map
// - 0xe0/0xe8 reads with map out
// - 0xc4 byte write in map, lane by parity
// - writing status bit 7 sets firmware enable
// - 0xcc aligned word write in map
// - 0xc0/0xc8 writes with map out
// - firmware enable gates background entry
`timescale 1ns/1ps
module sdbg_dev #(
   parameter int STEAL_WAIT = sdbg_pkg::STEAL_WAIT_CYC
) (
   // clock and reset
   input  wire logic               core_clk,
   input  wire logic               nrst,
   // debug link
   sdbg_if.dev                     link,
   // system bus
   input  wire logic               bus_free,
   input  wire sdbg_pkg::sdbg_word_t mem_rdata,
   output logic                    mem_req,
   output logic                    mem_we,
   output logic                    mem_inmap,
   output sdbg_pkg::sdbg_word_t    mem_addr,
   output logic [1:0]              mem_be,
   output sdbg_pkg::sdbg_word_t    mem_wdata,
   output logic                    cpu_freeze,
   // background state
   input  wire logic               bg_exit,
   output logic                    firmware_enable_bit,
   output logic                    bg_active
);
   import sdbg_pkg::*;

   localparam int WW = $clog2(STEAL_WAIT + 1);

   generate
      if (STEAL_WAIT < 1 || E_DIV != 2) begin : g_bad
         $error("sdbg_dev: unsupported steal wait or divider");
      end
   endgenerate

   typedef enum logic [2:0] {
      ST_CMD   = 3'b000,
      ST_ADDR  = 3'b001,
      ST_WDATA = 3'b010,
      ST_MEM   = 3'b011,
      ST_CAPT  = 3'b100,
      ST_RDATA = 3'b101
   } sdbg_dst_t;

   // ************************************************************
   // bus clock and bit timing
   // ************************************************************
   logic        ediv_r;
   logic        pin_prev_r;
   logic        cell_r;
   logic [4:0]  ecnt_r;
   logic        ebus;
   logic        fall;
   logic        samp;

   assign ebus = ediv_r;
   assign fall = pin_prev_r & ~link.pin;
   assign samp = cell_r & ebus & (ecnt_r == 5'(SAMPLE_E - 1));

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ediv_r <= 1'b0;
      end else begin
         ediv_r <= ~ediv_r;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pin_prev_r <= 1'b1;
         cell_r     <= 1'b0;
         ecnt_r     <= 5'h00;
      end else begin
         pin_prev_r <= link.pin;
         if (fall) begin
            cell_r <= 1'b1;
            ecnt_r <= 5'h00;
         end else if (cell_r && ebus) begin
            if (ecnt_r == 5'(CELL_E - 1)) begin
               cell_r <= 1'b0;
            end
            ecnt_r <= ecnt_r + 5'h01;
         end
      end
   end

   // ************************************************************
   // command sequencer
   // ************************************************************
   sdbg_dst_t  state_r;
   sdbg_byte_t op_r;
   sdbg_word_t addr_r;
   sdbg_word_t wdata_r;
   sdbg_word_t shreg_r;
   logic [4:0] bitcnt_r;
   logic [WW-1:0] wait_r;
   logic       is_local;
   logic       grant;
   logic       bg_set;
   logic       fw_set;
   sdbg_byte_t op_in;
   sdbg_byte_t status;

   assign op_in    = {shreg_r[6:0], link.pin};
   assign status   = {firmware_enable_bit, bg_active, 6'h00};
   assign is_local = op_is_inmap(op_r) && !op_is_word(op_r) && (addr_r == STATUS_ADDR);
   assign grant    = bus_free || (wait_r == WW'(STEAL_WAIT - 1));
   assign bg_set   = samp && (state_r == ST_CMD) && (bitcnt_r == 5'(CMD_BITS - 1))
                     && (op_in == BACKGROUND_CMD) && firmware_enable_bit;
   assign fw_set   = (state_r == ST_MEM) && is_local && !op_is_read(op_r)
                     && wdata_r[FW_EN_POS];

   // read data placed by address parity
   function automatic sdbg_word_t lane_rd(input sdbg_byte_t op, input logic odd,
                                          input sdbg_word_t d);
      if (op_is_word(op)) begin
         return d;
      end
      return odd ? {8'h00, d[7:0]} : {d[15:8], 8'h00};
   endfunction

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_r  <= ST_CMD;
         op_r     <= 8'h00;
         addr_r   <= 16'h0000;
         wdata_r  <= 16'h0000;
         shreg_r  <= 16'h0000;
         bitcnt_r <= 5'h00;
         wait_r   <= '0;
      end else begin
         unique case (state_r)
            ST_CMD: begin
               if (samp) begin
                  shreg_r  <= {shreg_r[14:0], link.pin};
                  bitcnt_r <= bitcnt_r + 5'h01;
                  if (bitcnt_r == 5'(CMD_BITS - 1)) begin
                     bitcnt_r <= 5'h00;
                     op_r     <= op_in;
                     if (op_is_mem(op_in)) begin
                        state_r <= ST_ADDR;
                     end
                  end
               end
            end
            ST_ADDR: begin
               if (samp) begin
                  shreg_r  <= {shreg_r[14:0], link.pin};
                  bitcnt_r <= bitcnt_r + 5'h01;
                  if (bitcnt_r == 5'(ADDR_BITS - 1)) begin
                     bitcnt_r <= 5'h00;
                     addr_r   <= {shreg_r[14:0], link.pin};
                     wait_r   <= '0;
                     state_r  <= op_is_read(op_r) ? ST_MEM : ST_WDATA;
                  end
               end
            end
            ST_WDATA: begin
               if (samp) begin
                  shreg_r  <= {shreg_r[14:0], link.pin};
                  bitcnt_r <= bitcnt_r + 5'h01;
                  if (bitcnt_r == 5'(DATA_BITS - 1)) begin
                     bitcnt_r <= 5'h00;
                     wdata_r  <= {shreg_r[14:0], link.pin};
                     wait_r   <= '0;
                     state_r  <= ST_MEM;
                  end
               end
            end
            ST_MEM: begin
               if (is_local) begin
                  shreg_r <= {8'h00, status};
                  state_r <= op_is_read(op_r) ? ST_RDATA : ST_CMD;
               end else if (grant) begin
                  state_r <= op_is_read(op_r) ? ST_CAPT : ST_CMD;
               end else begin
                  wait_r <= wait_r + WW'(1);
               end
            end
            ST_CAPT: begin
               shreg_r <= lane_rd(op_r, addr_r[0], mem_rdata);
               state_r <= ST_RDATA;
            end
            ST_RDATA: begin
               if (samp) begin
                  shreg_r  <= {shreg_r[14:0], 1'b0};
                  bitcnt_r <= bitcnt_r + 5'h01;
                  if (bitcnt_r == 5'(DATA_BITS - 1)) begin
                     bitcnt_r <= 5'h00;
                     state_r  <= ST_CMD;
                  end
               end
            end
            default: begin
               state_r <= ST_CMD;
            end
         endcase
      end
   end

   // ************************************************************
   // system bus access
   // ************************************************************
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         mem_req    <= 1'b0;
         mem_we     <= 1'b0;
         mem_inmap  <= 1'b0;
         mem_addr   <= 16'h0000;
         mem_be     <= 2'b00;
         mem_wdata  <= 16'h0000;
         cpu_freeze <= 1'b0;
      end else begin
         mem_req    <= 1'b0;
         cpu_freeze <= 1'b0;
         if ((state_r == ST_MEM) && !is_local && grant) begin
            mem_req    <= 1'b1;
            cpu_freeze <= ~bus_free;
            mem_we     <= ~op_is_read(op_r);
            mem_inmap  <= op_is_inmap(op_r);
            mem_wdata  <= wdata_r;
            if (op_is_word(op_r)) begin
               mem_addr <= {addr_r[15:1], 1'b0};
               mem_be   <= 2'b11;
            end else begin
               mem_addr <= addr_r;
               mem_be   <= addr_r[0] ? 2'b01 : 2'b10;
            end
         end
      end
   end

   // ************************************************************
   // status bits
   // ************************************************************
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         firmware_enable_bit <= FW_EN_RST;
      end else if (fw_set) begin
         firmware_enable_bit <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         bg_active <= BG_ACT_RST;
      end else if (bg_set) begin
         bg_active <= 1'b1;
      end else if (bg_exit) begin
         bg_active <= 1'b0;
      end
   end

   // ************************************************************
   // pin drive for returned bits
   // ************************************************************
   logic dev_oe_r;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         dev_oe_r <= 1'b0;
      end else if (fall && (state_r == ST_RDATA)) begin
         dev_oe_r <= ~shreg_r[15];
      end else if (ebus && (ecnt_r == 5'(DEV_DRIVE_E - 1))) begin
         dev_oe_r <= 1'b0;
      end
   end

   assign link.dev_o  = 1'b0;
   assign link.dev_oe = dev_oe_r;

endmodule

// ===== hdl/sdbg_host.sv
`timescale 1ns/1ps
module sdbg_host #(
   parameter int READ_GAP = sdbg_pkg::READ_GAP_E
) (
   // clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 nrst,
   // debug link
   sdbg_if.host                      link,
   // command request
   input  wire logic                 cmd_valid,
   input  wire sdbg_pkg::sdbg_byte_t cmd_op,
   input  wire sdbg_pkg::sdbg_word_t cmd_addr,
   input  wire sdbg_pkg::sdbg_word_t cmd_wdata,
   output logic                      cmd_ready,
   // read answer
   output logic                      rsp_valid,
   output sdbg_pkg::sdbg_word_t      rsp_data
);
   import sdbg_pkg::*;

   generate
      if (READ_GAP < 1 || READ_GAP > 255) begin : g_bad
         $error("sdbg_host: read gap out of range");
      end
   endgenerate

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_SEND = 2'b01,
      H_GAP  = 2'b10,
      H_RECV = 2'b11
   } sdbg_hst_t;

   // ************************************************************
   // bit cell generator
   // ************************************************************
   sdbg_hst_t         state_r;
   logic              ediv_r;
   logic [4:0]        hcnt_r;
   logic [7:0]        gcnt_r;
   logic [5:0]        bits_r;
   logic [FRAME_MAX-1:0] tx_r;
   logic              rd_r;
   sdbg_word_t        rx_r;
   logic              host_oe_r;
   logic              cell_end;
   logic [4:0]        low_len;

   assign cmd_ready = (state_r == H_IDLE);
   assign cell_end  = ediv_r && (hcnt_r == 5'(CELL_E - 1));
   assign low_len   = (state_r == H_RECV) ? 5'(HOST_START_E) :
                      tx_r[FRAME_MAX-1] ? 5'(HOST_ONE_E) : 5'(HOST_ZERO_E);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ediv_r <= 1'b0;
      end else if (cmd_ready && cmd_valid) begin
         // restart divider so the first cell is not short
         ediv_r <= 1'b0;
      end else begin
         ediv_r <= ~ediv_r;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         hcnt_r <= 5'h00;
      end else if ((state_r == H_SEND) || (state_r == H_RECV)) begin
         if (ediv_r) begin
            hcnt_r <= cell_end ? 5'h00 : hcnt_r + 5'h01;
         end
      end else begin
         hcnt_r <= 5'h00;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         host_oe_r <= 1'b0;
      end else begin
         host_oe_r <= ((state_r == H_SEND) || (state_r == H_RECV))
                      && (hcnt_r < low_len);
      end
   end

   assign link.host_o  = 1'b0;
   assign link.host_oe = host_oe_r;

   // ************************************************************
   // frame sequencer
   // ************************************************************
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_r   <= H_IDLE;
         tx_r      <= '0;
         bits_r    <= 6'h00;
         gcnt_r    <= 8'h00;
         rd_r      <= 1'b0;
         rx_r      <= 16'h0000;
         rsp_valid <= 1'b0;
         rsp_data  <= 16'h0000;
      end else begin
         rsp_valid <= 1'b0;
         unique case (state_r)
            H_IDLE: begin
               if (cmd_valid) begin
                  tx_r    <= {cmd_op, cmd_addr, cmd_wdata};
                  rd_r    <= op_is_mem(cmd_op) && op_is_read(cmd_op);
                  state_r <= H_SEND;
                  if (!op_is_mem(cmd_op)) begin
                     bits_r <= 6'(CMD_BITS);
                  end else if (op_is_read(cmd_op)) begin
                     bits_r <= 6'(CMD_BITS + ADDR_BITS);
                  end else begin
                     bits_r <= 6'(FRAME_MAX);
                  end
               end
            end
            H_SEND: begin
               if (cell_end) begin
                  tx_r   <= {tx_r[FRAME_MAX-2:0], 1'b0};
                  bits_r <= bits_r - 6'h01;
                  if (bits_r == 6'h01) begin
                     gcnt_r  <= 8'h00;
                     state_r <= H_GAP;
                  end
               end
            end
            H_GAP: begin
               if (ediv_r) begin
                  gcnt_r <= gcnt_r + 8'h01;
                  if (gcnt_r == 8'(READ_GAP - 1)) begin
                     bits_r  <= 6'(DATA_BITS);
                     state_r <= rd_r ? H_RECV : H_IDLE;
                  end
               end
            end
            H_RECV: begin
               if (ediv_r && (hcnt_r == 5'(HOST_SAMPLE_E))) begin
                  rx_r <= {rx_r[14:0], link.pin};
               end
               if (cell_end) begin
                  bits_r <= bits_r - 6'h01;
                  if (bits_r == 6'h01) begin
                     rsp_valid <= 1'b1;
                     rsp_data  <= rx_r;
                     state_r   <= H_IDLE;
                  end
               end
            end
         endcase
      end
   end

endmodule

// ===== hdl/sdbg_if.sv
`timescale 1ns/1ps
interface sdbg_if;
   logic host_o;
   logic host_oe;
   logic dev_o;
   logic dev_oe;
   logic pin;

   // wired-and of the two open-drain drivers, pulled up when idle
   assign pin = ~((host_oe & ~host_o) | (dev_oe & ~dev_o));

   modport dev  (input pin, output dev_o, output dev_oe);
   modport host (input pin, output host_o, output host_oe);
endinterface

// ===== hdl/sdbg_pkg.sv
package sdbg_pkg;

   // ************************************************************
   // opcodes of the hardware command set
   // ************************************************************
   localparam logic [7:0] BACKGROUND_CMD       = 8'h90;
   localparam logic [7:0] READ_INMAP_BYTE_CMD  = 8'he4;
   localparam logic [7:0] READ_INMAP_WORD_CMD  = 8'hec;
   localparam logic [7:0] READ_BYTE_CMD        = 8'he0;
   localparam logic [7:0] READ_WORD_CMD        = 8'he8;
   localparam logic [7:0] WRITE_INMAP_BYTE_CMD = 8'hc4;
   localparam logic [7:0] WRITE_INMAP_WORD_CMD = 8'hcc;
   localparam logic [7:0] WRITE_BYTE_CMD       = 8'hc0;
   localparam logic [7:0] WRITE_WORD_CMD       = 8'hc8;

   // ************************************************************
   // status byte in the debug map
   // ************************************************************
   localparam logic [15:0] STATUS_ADDR  = 16'hff01;
   localparam int          FW_EN_POS    = 7;
   localparam int          BG_ACT_POS   = 6;
   localparam logic        FW_EN_RST    = 1'b0;
   localparam logic        BG_ACT_RST   = 1'b0;

   // ************************************************************
   // frame layout
   // ************************************************************
   localparam int CMD_BITS  = 8;
   localparam int ADDR_BITS = 16;
   localparam int DATA_BITS = 16;
   localparam int FRAME_MAX = CMD_BITS + ADDR_BITS + DATA_BITS;

   // ************************************************************
   // timing, in bus-clock cycles unless noted
   // ************************************************************
   localparam int E_DIV         = 2;
   localparam int CELL_E        = 16;
   localparam int SAMPLE_E      = 9;
   localparam int DEV_DRIVE_E   = 13;
   localparam int HOST_ONE_E    = 4;
   localparam int HOST_ZERO_E   = 13;
   localparam int HOST_START_E  = 2;
   localparam int HOST_SAMPLE_E = 10;
   localparam int STEAL_WAIT_E  = 32;
   localparam int STEAL_WAIT_CYC = STEAL_WAIT_E * E_DIV;
   localparam int READ_GAP_E    = STEAL_WAIT_E + 8;

   typedef logic [15:0] sdbg_word_t;
   typedef logic [7:0]  sdbg_byte_t;

   // ************************************************************
   // opcode decoding
   // ************************************************************
   function automatic logic op_is_mem(input sdbg_byte_t op);
      return (op[7:6] == 2'b11) && !op[4] && (op[1:0] == 2'b00);
   endfunction

   function automatic logic op_is_read(input sdbg_byte_t op);
      return op[5];
   endfunction

   function automatic logic op_is_word(input sdbg_byte_t op);
      return op[3];
   endfunction

   function automatic logic op_is_inmap(input sdbg_byte_t op);
      return op[2];
   endfunction

endpackage

// ===== verification/sdbg_checker.sv
`timescale 1ns/1ps
// ************************************************************
// wire and bus access checks
// ************************************************************
module sdbg_checker (
   // clock and reset
   input wire logic                 core_clk,
   input wire logic                 nrst,
   // debug link
   input wire logic                 host_o,
   input wire logic                 host_oe,
   input wire logic                 dev_o,
   input wire logic                 dev_oe,
   input wire logic                 pin,
   // system bus
   input wire logic                 bus_free,
   input wire logic                 mem_req,
   input wire logic                 cpu_freeze,
   input wire sdbg_pkg::sdbg_word_t mem_addr,
   input wire logic [1:0]           mem_be
);
   import sdbg_pkg::*;

   logic [7:0] gap_r;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   // cycles since the host last pulled the pin
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         gap_r <= 8'hff;
      end else if ($rose(host_oe)) begin
         gap_r <= 8'h00;
      end else if (gap_r != 8'hff) begin
         gap_r <= gap_r + 8'h01;
      end
   end

   drivers_low_a: assert property (!host_o && !dev_o)
      else $error("open-drain data not low");
   pin_wired_a: assert property (pin == !(host_oe || dev_oe))
      else $error("pin level not the wired result");
   host_pulse_min_a: assert property ($rose(host_oe) |-> host_oe[*4])
      else $error("host pulse too short");
   host_pulse_max_a: assert property ($rose(host_oe) |-> ##[4:28] !host_oe)
      else $error("host pulse too long");
   cell_spacing_a: assert property ($rose(host_oe) && gap_r != 8'hff |-> gap_r >= 8'd31)
      else $error("bit cells closer than 32 cycles");
   dev_follow_a: assert property ($rose(dev_oe) |-> host_oe)
      else $error("device drove without host edge");
   dev_release_a: assert property ($rose(dev_oe) |-> dev_oe[*8] ##[10:26] !dev_oe)
      else $error("device drive length wrong");
   req_pulse_a: assert property (mem_req |=> !mem_req)
      else $error("access longer than one cycle");
   idle_cycle_a: assert property (mem_req && !cpu_freeze |-> $past(bus_free))
      else $error("access without idle cycle");
   steal_busy_a: assert property (cpu_freeze |-> mem_req && !$past(bus_free))
      else $error("freeze without steal");
   word_align_a: assert property (mem_req && mem_be == 2'b11 |-> !mem_addr[0])
      else $error("word access not aligned");
   byte_lane_a: assert property (mem_req && mem_be != 2'b11 |-> mem_be == {!mem_addr[0], mem_addr[0]})
      else $error("byte lane wrong");

   steal_c: cover property (cpu_freeze);
   idle_c: cover property (mem_req && !cpu_freeze);
   dev_drive_c: cover property ($rose(dev_oe));
   byte_acc_c: cover property (mem_req && mem_be != 2'b11);
endmodule

// ===== verification/sdbg_tb_top.sv
`timescale 1ns/1ps
module sdbg_tb_top;
   import sdbg_pkg::*;

   logic        core_clk, nrst, bus_free, busy, bg_exit, cmd_valid;
   logic        cmd_ready, rsp_valid, mem_req, mem_we, mem_inmap, cpu_freeze, fw_en, bg_act;
   logic        last_we, last_inmap;
   logic [1:0]  mem_be, last_be;
   logic [63:0] sh;
   sdbg_byte_t  cmd_op;
   sdbg_byte_t  mem [0:65535];
   sdbg_word_t  cmd_addr, cmd_wdata, mem_rdata, rsp_data, mem_addr, mem_wdata, a, d;
   int          nbits, lowrun, n_acc, n_frz, f0, n_fail, compares;
   sdbg_byte_t  wr_ops [4] = '{8'hc4, 8'hcc, 8'hc0, 8'hc8};
   sdbg_byte_t  rd_ops [4] = '{8'he0, 8'he8, 8'he4, 8'hec};

   sdbg_if lnk ();
   sdbg_dev #(.STEAL_WAIT(8)) u_sdbg_dev (
      .core_clk(core_clk), .nrst(nrst), .link(lnk.dev), .bus_free(bus_free),
      .mem_rdata(mem_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_inmap(mem_inmap),
      .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .cpu_freeze(cpu_freeze),
      .bg_exit(bg_exit), .firmware_enable_bit(fw_en), .bg_active(bg_act));
   sdbg_host #(.READ_GAP(12)) u_sdbg_host (
      .core_clk(core_clk), .nrst(nrst), .link(lnk.host), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   sdbg_checker u_sdbg_checker (
      .core_clk(core_clk), .nrst(nrst), .host_o(lnk.host_o), .host_oe(lnk.host_oe),
      .dev_o(lnk.dev_o), .dev_oe(lnk.dev_oe), .pin(lnk.pin), .bus_free(bus_free),
      .mem_req(mem_req), .cpu_freeze(cpu_freeze), .mem_addr(mem_addr), .mem_be(mem_be));

   always #4 core_clk = ~core_clk;

   // ************************************************************
   // system bus memory and wire decoder
   // ************************************************************
   always @(posedge core_clk) begin
      #1;
      bus_free = !busy;
      mem_rdata = sdbg_word_t'($urandom);
      if (mem_req) begin
         if (mem_we && mem_be[1]) mem[{mem_addr[15:1], 1'b0}] = mem_wdata[15:8];
         if (mem_we && mem_be[0]) mem[{mem_addr[15:1], 1'b1}] = mem_wdata[7:0];
         mem_rdata = {mem[{mem_addr[15:1], 1'b0}], mem[{mem_addr[15:1], 1'b1}]};
         {last_we, last_inmap, last_be} = {mem_we, mem_inmap, mem_be};
         n_acc++;
         n_frz += int'(cpu_freeze);
      end
   end

   // short low = 1, long low = 0
   always @(posedge core_clk) begin
      if (!lnk.pin) begin
         lowrun++;
      end else if (lowrun > 0) begin
         sh = {sh[62:0], lowrun < 17};
         nbits++;
         lowrun = 0;
      end
   end

   // ************************************************************
   // tasks
   // ************************************************************
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // one frame; r is the data expected on the wire after the address
   task automatic run(input sdbg_byte_t op, input sdbg_word_t ad, input sdbg_word_t dt,
                      input sdbg_word_t r);
      int n;
      nbits = 0;
      {cmd_valid, cmd_op, cmd_addr, cmd_wdata} = {1'b1, op, ad, dt};
      @(posedge core_clk);
      #1 cmd_valid = 1'b0;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 4000) begin
         @(posedge core_clk);
         #1 n++;
      end
      if (op == BACKGROUND_CMD) begin
         check(64'(nbits), 64'd8);
         check(sh[7:0], op);
      end else begin
         check(64'(nbits), 64'd40);
         check(sh[39:0], {op, ad, r});
      end
      check(rsp_valid, op[7:5] == 3'b111);
      if (op[7:5] == 3'b111) check(rsp_data, r);
      check(lnk.pin, 1'b1);
   endtask

   function automatic sdbg_word_t lane(input sdbg_byte_t op, input sdbg_word_t ad,
                                      input sdbg_word_t dt);
      if (op[3]) return dt;
      return ad[0] ? {8'h00, dt[7:0]} : {dt[15:8], 8'h00};
   endfunction

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      {core_clk, nrst, busy, bg_exit, cmd_valid} = 5'h00;
      {cmd_op, cmd_addr, cmd_wdata} = '0;
      {nbits, lowrun, n_acc, n_frz, n_fail, compares} = '0;
      void'($urandom(56));
      repeat (6) @(posedge core_clk);
      #1 nrst = 1'b1;
      check({cmd_ready, fw_en, bg_act, lnk.pin, rsp_data}, {4'b1001, 16'h0000});
      $display("reset test done");
      run(READ_INMAP_BYTE_CMD, STATUS_ADDR, 16'h0000, 16'h0000);
      run(BACKGROUND_CMD, 16'h0000, 16'h0000, 16'h0000);
      check(bg_act, 1'b0);
      run(WRITE_INMAP_BYTE_CMD, STATUS_ADDR, 16'h0080, 16'h0080);
      check(fw_en, 1'b1);
      run(READ_INMAP_BYTE_CMD, STATUS_ADDR, 16'h0000, 16'h0080);
      check(64'(n_acc), 64'd0);
      run(BACKGROUND_CMD, 16'h0000, 16'h0000, 16'h0000);
      check(bg_act, 1'b1);
      run(READ_INMAP_BYTE_CMD, STATUS_ADDR, 16'h0000, 16'h00c0);
      @(posedge core_clk);
      #1 bg_exit = 1'b1;
      @(posedge core_clk);
      #1 bg_exit = 1'b0;
      check(bg_act, 1'b0);
      $display("status test done");
      for (int i = 0; i < 16; i++) begin
         busy = 1'($urandom);
         a = sdbg_word_t'($urandom) & 16'hfeff;
         d = sdbg_word_t'($urandom);
         if (wr_ops[i%4][3]) a[0] = 1'b0;
         f0 = n_frz;
         run(wr_ops[i%4], a, d, d);
         check({last_we, last_inmap}, {1'b1, wr_ops[i%4][2]});
         check(last_be, wr_ops[i%4][3] ? 2'b11 : {!a[0], a[0]});
         run(rd_ops[i%4], a, 16'h0000, lane(rd_ops[i%4], a, d));
         check({last_we, last_inmap}, {1'b0, rd_ops[i%4][2]});
         check(64'(n_frz - f0), busy ? 64'd2 : 64'd0);
      end
      $display("memory test done");
      report_and_stop();
   end

   initial begin
      #800000;
      n_fail++;
      report_and_stop();
   end
endmodule
